// ---- verilog/pmv_pkg.sv ----
package pmv_pkg;

  localparam int ADDR_W = 24;
  localparam int WORD_W = 24;
  localparam int HALF_W = 16;
  localparam int CFG_W = 16;
  localparam int OPC_W = 8;

  typedef logic [ADDR_W-1:0] pmv_addr_t;
  typedef logic [WORD_W-1:0] pmv_word_t;
  typedef logic [HALF_W-1:0] pmv_half_t;

  // field layout of one 24-bit program location
  localparam int LOW_MSB = 15;
  localparam int UPPER_LSB = 16;
  localparam int UPPER_MSB = 23;
  localparam int TARGET_MSB = 22;
  localparam logic [7:0] UNIMPL_BYTE = 8'h00;

  // program counter stepping and vector layout
  localparam pmv_addr_t PC_STEP = 24'h000002;
  localparam pmv_addr_t PC_RESET = 24'h000000;
  localparam pmv_addr_t RESV_END = 24'h000200;
  localparam pmv_addr_t PRI_JUMP = 24'h000000;
  localparam pmv_addr_t PRI_TARGET = 24'h000002;
  localparam pmv_addr_t AUX_JUMP = 24'h7FFFFC;
  localparam pmv_addr_t AUX_TARGET = 24'h7FFFFE;
  localparam pmv_addr_t AUX_END = 24'h800000;

  // position of reset_vector_select in power_on_config_word
  localparam int RSTSEL_BIT = 0;

  typedef enum logic [1:0] {
    PMV_STRAP,
    PMV_VEC_JUMP,
    PMV_VEC_TARGET,
    PMV_RUN
  } pmv_state_e;

endpackage

// ---- verilog/pmv_mem_if.sv ----
interface pmv_mem_if;
  pmv_pkg::pmv_addr_t fetch_addr;
  pmv_pkg::pmv_word_t fetch_data;
  pmv_pkg::pmv_addr_t ds_addr;
  pmv_pkg::pmv_half_t ds_data;
  logic wr_en;
  pmv_pkg::pmv_addr_t wr_addr;
  pmv_pkg::pmv_word_t wr_data;

  modport ctrl (
    output fetch_addr,
    output ds_addr,
    output wr_en,
    output wr_addr,
    output wr_data,
    input fetch_data,
    input ds_data
  );

  modport mem (
    input fetch_addr,
    input ds_addr,
    input wr_en,
    input wr_addr,
    input wr_data,
    output fetch_data,
    output ds_data
  );
endinterface

// ---- verilog/pmv_mem.sv ----
module pmv_mem #(
  parameter int PRI_WORDS = 1024,
  parameter int AUX_WORDS = 64
) (
  input wire logic ref_clk,
  pmv_mem_if.mem bus
);

  localparam int TOTAL = PRI_WORDS + AUX_WORDS;
  localparam int IDX_W = $clog2(TOTAL);
  localparam pmv_pkg::pmv_addr_t AUX_BASE =
    pmv_pkg::ADDR_W'(pmv_pkg::AUX_END - pmv_pkg::ADDR_W'(2 * AUX_WORDS));

  // 24 bits per location: low word plus the implemented upper byte
  pmv_pkg::pmv_word_t store [TOTAL];

  // map a byte-style address onto the array; top bit flags a hit
  function automatic logic [IDX_W:0] map_idx(input pmv_pkg::pmv_addr_t a);
    logic [pmv_pkg::ADDR_W-1:0] w;
    w = a >> 1; // even and odd halves share a location
    // anything at or past the auxiliary end is unmapped, not aliased
    if (a >= AUX_BASE && a < pmv_pkg::AUX_END) begin
      map_idx = {1'b1, IDX_W'(PRI_WORDS + int'((a - AUX_BASE) >> 1))};
    end else if (w < pmv_pkg::ADDR_W'(PRI_WORDS)) begin
      map_idx = {1'b1, IDX_W'(w)};
    end else begin
      map_idx = '0;
    end
  endfunction

  logic [IDX_W:0] f_idx;
  logic [IDX_W:0] d_idx;
  logic [IDX_W:0] w_idx;
  pmv_pkg::pmv_word_t d_word;

  // asynchronous read for fetch and data-space view
  always_comb begin
    f_idx = map_idx(bus.fetch_addr);
    d_idx = map_idx(bus.ds_addr);
    w_idx = map_idx(bus.wr_addr);
    bus.fetch_data = f_idx[IDX_W] ? store[f_idx[IDX_W-1:0]] : '0;
    d_word = d_idx[IDX_W] ? store[d_idx[IDX_W-1:0]] : '0;
    // odd address shows upper word with its dead byte as zero
    if (bus.ds_addr[0]) begin
      bus.ds_data = {pmv_pkg::UNIMPL_BYTE,
                     d_word[pmv_pkg::UPPER_MSB:pmv_pkg::UPPER_LSB]};
    end else begin
      bus.ds_data = d_word[pmv_pkg::LOW_MSB:0];
    end
  end

  // image programming port
  always_ff @(posedge ref_clk) begin
    if (bus.wr_en && w_idx[IDX_W]) begin
      store[w_idx[IDX_W-1:0]] <= bus.wr_data;
    end
  end

endmodule

// ---- verilog/pmv_top.sv ----
module pmv_top #(
  parameter int PRI_WORDS = 1024,
  parameter int AUX_WORDS = 64,
  parameter logic [7:0] JUMP_OPCODE = 8'h3C
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pmv_pkg::CFG_W-1:0] power_on_config_word,
  input wire logic pc_step,
  input wire logic pc_back,
  input wire logic pc_jump,
  input wire pmv_pkg::pmv_addr_t pc_jump_addr,
  input wire logic ds_rd,
  input wire pmv_pkg::pmv_addr_t ds_addr,
  input wire logic pm_wr_en,
  input wire pmv_pkg::pmv_addr_t pm_wr_addr,
  input wire pmv_pkg::pmv_word_t pm_wr_data,
  output pmv_pkg::pmv_addr_t pc,
  output pmv_pkg::pmv_word_t instr,
  output logic instr_valid,
  output pmv_pkg::pmv_half_t ds_data,
  output logic ds_valid,
  output logic boot_done,
  output logic vector_error,
  output logic reset_vector_select,
  output logic in_vector_region
);

  pmv_mem_if mem_if ();

  pmv_mem #(
    .PRI_WORDS(PRI_WORDS),
    .AUX_WORDS(AUX_WORDS)
  ) u_mem (
    .ref_clk(ref_clk),
    .bus(mem_if.mem)
  );

  pmv_pkg::pmv_state_e state_r, state_nxt;
  pmv_pkg::pmv_addr_t pc_r, pc_nxt;
  pmv_pkg::pmv_word_t instr_r, instr_nxt;
  logic instr_valid_r, instr_valid_nxt;
  pmv_pkg::pmv_half_t ds_data_r, ds_data_nxt;
  logic ds_valid_r, ds_valid_nxt;
  logic boot_done_r, boot_done_nxt;
  logic vector_error_r, vector_error_nxt;
  logic sel_r, sel_nxt;
  logic in_vec_r, in_vec_nxt;
  pmv_pkg::pmv_addr_t tgt;

  // programming and data-space ports pass straight to the array
  assign mem_if.wr_en = pm_wr_en;
  assign mem_if.wr_addr = pm_wr_addr;
  assign mem_if.wr_data = pm_wr_data;
  assign mem_if.ds_addr = ds_addr;

  // boot sequencer and program counter next state
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    sel_nxt = sel_r;
    boot_done_nxt = boot_done_r;
    vector_error_nxt = vector_error_r;
    instr_nxt = instr_r;
    instr_valid_nxt = 1'b0;
    mem_if.fetch_addr = pc_r;
    tgt = {1'b0, mem_if.fetch_data[pmv_pkg::TARGET_MSB:1], 1'b0};
    case (state_r)
      pmv_pkg::PMV_STRAP: begin
        // strap caught by a clock edge after reset release
        sel_nxt = power_on_config_word[pmv_pkg::RSTSEL_BIT];
        state_nxt = pmv_pkg::PMV_VEC_JUMP;
      end
      pmv_pkg::PMV_VEC_JUMP: begin
        mem_if.fetch_addr = sel_r ? pmv_pkg::AUX_JUMP : pmv_pkg::PRI_JUMP;
        // image must place the jump here
        if (mem_if.fetch_data[pmv_pkg::UPPER_MSB:pmv_pkg::UPPER_LSB] != JUMP_OPCODE) begin
          vector_error_nxt = 1'b1;
        end
        state_nxt = pmv_pkg::PMV_VEC_TARGET;
      end
      pmv_pkg::PMV_VEC_TARGET: begin
        mem_if.fetch_addr = sel_r ? pmv_pkg::AUX_TARGET : pmv_pkg::PRI_TARGET;
        pc_nxt = tgt;
        // start of code must lie above the vector area
        if (tgt < pmv_pkg::RESV_END) begin
          vector_error_nxt = 1'b1;
        end
        boot_done_nxt = 1'b1;
        state_nxt = pmv_pkg::PMV_RUN;
      end
      default: begin
        // jump wins over step, step over back; bit 0 always clear
        if (pc_jump) begin
          pc_nxt = {pc_jump_addr[pmv_pkg::ADDR_W-1:1], 1'b0};
        end else if (pc_step) begin
          pc_nxt = pmv_pkg::ADDR_W'(pc_r + pmv_pkg::PC_STEP);
        end else if (pc_back) begin
          pc_nxt = pmv_pkg::ADDR_W'(pc_r - pmv_pkg::PC_STEP);
        end
        mem_if.fetch_addr = pc_nxt;
        instr_nxt = mem_if.fetch_data;
        instr_valid_nxt = 1'b1;
      end
    endcase
    in_vec_nxt = pc_nxt < pmv_pkg::RESV_END;
  end

  // data-space read result, one cycle after the strobe
  always_comb begin
    ds_valid_nxt = ds_rd;
    ds_data_nxt = ds_rd ? mem_if.ds_data : ds_data_r;
  end

  // register all state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= pmv_pkg::PMV_STRAP;
      pc_r <= pmv_pkg::PC_RESET;
      sel_r <= 1'b0;
      boot_done_r <= 1'b0;
      vector_error_r <= 1'b0;
      instr_r <= '0;
      instr_valid_r <= 1'b0;
      ds_data_r <= '0;
      ds_valid_r <= 1'b0;
      in_vec_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      sel_r <= sel_nxt;
      boot_done_r <= boot_done_nxt;
      vector_error_r <= vector_error_nxt;
      instr_r <= instr_nxt;
      instr_valid_r <= instr_valid_nxt;
      ds_data_r <= ds_data_nxt;
      ds_valid_r <= ds_valid_nxt;
      in_vec_r <= in_vec_nxt;
    end
  end

  assign pc = pc_r;
  assign instr = instr_r;
  assign instr_valid = instr_valid_r;
  assign ds_data = ds_data_r;
  assign ds_valid = ds_valid_r;
  assign boot_done = boot_done_r;
  assign vector_error = vector_error_r;
  assign reset_vector_select = sel_r;
  assign in_vector_region = in_vec_r;

  // checks on the sequencer, counter and data-space read
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_pc_even;
    pc_r[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc odd");

  property p_step;
    state_r == pmv_pkg::PMV_RUN && pc_step && !pc_jump
      |=> pc_r == pmv_pkg::ADDR_W'($past(pc_r) + pmv_pkg::PC_STEP);
  endproperty
  a_step: assert property (p_step) else $error("step not two");

  property p_back;
    state_r == pmv_pkg::PMV_RUN && pc_back && !pc_step && !pc_jump
      |=> pc_r == pmv_pkg::ADDR_W'($past(pc_r) - pmv_pkg::PC_STEP);
  endproperty
  a_back: assert property (p_back) else $error("back not two");

  property p_hold;
    state_r == pmv_pkg::PMV_RUN && !pc_step && !pc_back && !pc_jump |=> $stable(pc_r);
  endproperty
  a_hold: assert property (p_hold) else $error("pc moved idle");

  property p_boot_len;
    state_r == pmv_pkg::PMV_STRAP |-> ##3 boot_done_r && state_r == pmv_pkg::PMV_RUN;
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot not 3 cycles");

  property p_boot_tgt;
    $rose(boot_done_r) |->
      pc_r == {1'b0, $past(mem_if.fetch_data[pmv_pkg::TARGET_MSB:1]), 1'b0};
  endproperty
  a_boot_tgt: assert property (p_boot_tgt) else $error("bad start pc");

  property p_vec_loc;
    state_r == pmv_pkg::PMV_VEC_JUMP |->
      mem_if.fetch_addr == (sel_r ? pmv_pkg::AUX_JUMP : pmv_pkg::PRI_JUMP)
      ##1 mem_if.fetch_addr == (sel_r ? pmv_pkg::AUX_TARGET : pmv_pkg::PRI_TARGET);
  endproperty
  a_vec_loc: assert property (p_vec_loc) else $error("wrong vector loc");

  property p_resv;
    $rose(boot_done_r) && pc_r < pmv_pkg::RESV_END |-> vector_error_r;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved start missed");

  property p_ds_zero;
    // a strobe seen while in reset is not served, so it is left out
    $past(ds_rd) && $past(ds_addr[0]) && !$past(rst) |->
      ds_valid_r &&
      ds_data_r[pmv_pkg::LOW_MSB:pmv_pkg::HALF_W-pmv_pkg::OPC_W] == pmv_pkg::UNIMPL_BYTE;
  endproperty
  a_ds_zero: assert property (p_ds_zero) else $error("dead byte nonzero");

  property p_instr_valid;
    instr_valid_r |-> $past(state_r) == pmv_pkg::PMV_RUN;
  endproperty
  a_instr_valid: assert property (p_instr_valid) else $error("fetch before boot");

  c_boot: cover property ($rose(boot_done_r));
  c_aux: cover property ($rose(boot_done_r) && sel_r);
  c_step: cover property (state_r == pmv_pkg::PMV_RUN && pc_step ##1 pc_step);
  c_ds_odd: cover property (ds_rd && ds_addr[0]);
  c_bad_image: cover property ($rose(boot_done_r) && vector_error_r);

endmodule

// ---- bench/pmv_core_model.sv ----
// core side image loader: writes both reset locations while load is high
module pmv_core_model #(
  parameter logic [7:0] OPC = 8'h3C,
  parameter logic [23:0] PRI_T = 24'h000400,
  parameter logic [23:0] AUX_T = 24'h000600,
  parameter logic [23:0] LOW_T = 24'h000100
) (
  input wire logic ref_clk,
  input wire logic load,
  input wire logic bad,
  input wire logic low,
  output logic wr_en,
  output pmv_pkg::pmv_addr_t wr_addr,
  output pmv_pkg::pmv_word_t wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_r = 3'h0;
  logic [7:0] opc;
  // word counter, restarts whenever load drops
  always @(posedge ref_clk) begin
    if (!load)
      cnt_r <= 3'h0;
    else if (cnt_r < 3'h4)
      cnt_r <= cnt_r + 3'h1;
  end
  // bad flips the opcode so the device sees a broken image
  // low puts the start target inside the vector area
  assign opc = bad ? ~OPC : OPC;
  assign wr_en = load && (cnt_r < 3'h4);
  // jump word then target word, primary first, auxiliary after
  assign wr_addr = (cnt_r[1] ? pmv_pkg::AUX_JUMP : pmv_pkg::PRI_JUMP) + 24'({cnt_r[0], 1'b0});
  always_comb begin
    if (!cnt_r[0])
      wr_data = {opc, 16'h0000};
    else
      wr_data = low ? LOW_T : (cnt_r[1] ? AUX_T : PRI_T);
  end
endmodule

// ---- bench/test_program_memory_reset_vector_map.sv ----
module test_program_memory_reset_vector_map;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] PRI_T = 24'h000400;
  localparam logic [23:0] AUX_T = 24'h000600;
  localparam logic [23:0] LOW_T = 24'h000100;
  localparam logic [23:0] JW = 24'h3C0000;
  typedef struct packed {logic [23:0] a; logic [15:0] d;} pmv_row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] cfg = 16'h0000;
  logic pc_step, pc_back, pc_jump, ds_rd, load, bad, low, wr_en;
  logic instr_valid, ds_valid, boot_done, vector_error, rvs, in_vr;
  pmv_pkg::pmv_addr_t pc_jump_addr, ds_addr, pc, wr_addr;
  pmv_pkg::pmv_word_t instr, wr_data;
  pmv_pkg::pmv_half_t ds_data;
  int fail_count = 0;
  int checks = 0;
  // data space view of the loaded vectors, last row unmapped
  pmv_row_s rows [8] = '{{24'h000000, 16'h0000}, {24'h000001, 16'h003C},
    {24'h000002, 16'h0400}, {24'h000003, 16'h0000}, {24'h7FFFFC, 16'h0000},
    {24'h7FFFFD, 16'h003C}, {24'h7FFFFE, 16'h0600}, {24'h200000, 16'h0000}};

  always #20 ref_clk = ~ref_clk;

  pmv_top dut_u (.ref_clk(ref_clk), .rst(rst), .power_on_config_word(cfg),
    .pc_step(pc_step), .pc_back(pc_back), .pc_jump(pc_jump), .pc_jump_addr(pc_jump_addr),
    .ds_rd(ds_rd), .ds_addr(ds_addr), .pm_wr_en(wr_en), .pm_wr_addr(wr_addr),
    .pm_wr_data(wr_data), .pc(pc), .instr(instr), .instr_valid(instr_valid),
    .ds_data(ds_data), .ds_valid(ds_valid), .boot_done(boot_done),
    .vector_error(vector_error), .reset_vector_select(rvs), .in_vector_region(in_vr));

  pmv_core_model #(.PRI_T(PRI_T), .AUX_T(AUX_T), .LOW_T(LOW_T)) core_u (.ref_clk(ref_clk),
    .load(load), .bad(bad), .low(low), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

  task cmp_val(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task tick;
    @(posedge ref_clk);
    #1;
  endtask

  // reset, image load, and boot through the chosen vector
  task boot(input logic aux, input logic bd, input logic lo);
    rst = 1'b1;
    cfg = {15'h0000, aux};
    load = 1'b0;
    bad = bd;
    low = lo;
    pc_step = 1'b1;
    tick;
    cmp_val(pc, 24'h000000);
    cmp_bit(in_vr, 1'b1);
    load = 1'b1;
    repeat (5) tick;
    rst = 1'b0;
    load = 1'b0;
    repeat (2) tick;
    cmp_bit(boot_done, 1'b0);
    tick;
    cmp_bit(boot_done, 1'b1);
    cmp_val(pc, lo ? LOW_T : (aux ? AUX_T : PRI_T));
    cmp_bit(rvs, aux);
    cmp_bit(vector_error, bd | lo);
    cmp_bit(in_vr, lo);
    {pc_step, pc_back, pc_jump} = 3'h0;
  endtask

  // one pc request, then pc, region flag and fetch valid flag
  task pc_op(input logic [2:0] sbj, input logic [23:0] ja, input logic [23:0] epc);
    {pc_step, pc_back, pc_jump} = sbj;
    pc_jump_addr = ja;
    tick;
    cmp_val(pc, epc);
    cmp_bit(in_vr, epc < 24'h000200);
    cmp_bit(instr_valid, 1'b1);
  endtask

  task test_done;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, run needs about 52 cycles
  initial begin
    #20000;
    fail_count++;
    test_done;
  end

  initial begin
    {pc_step, pc_back, pc_jump, ds_rd, load, bad, low} = 7'h00;
    pc_jump_addr = 24'h000000;
    ds_addr = 24'h000000;
    boot(1'b0, 1'b0, 1'b0);
    // back to back data space reads of the vector words
    ds_rd = 1'b1;
    foreach (rows[i]) begin
      ds_addr = rows[i].a;
      tick;
      cmp_bit(ds_valid, 1'b1);
      cmp_val({8'h00, ds_data}, {8'h00, rows[i].d});
    end
    ds_rd = 1'b0;
    tick;
    cmp_bit(ds_valid, 1'b0);
    pc_op(3'h1, 24'h000001, 24'h000000);
    cmp_val(instr, JW);
    pc_op(3'h4, 24'h000000, 24'h000002);
    cmp_val(instr, PRI_T);
    pc_op(3'h4, 24'h000000, 24'h000004);
    pc_op(3'h2, 24'h000000, 24'h000002);
    pc_op(3'h2, 24'h000000, 24'h000000);
    cmp_val(instr, JW);
    pc_op(3'h7, 24'h0001FF, 24'h0001FE);
    pc_op(3'h1, 24'h000200, 24'h000200);
    boot(1'b1, 1'b0, 1'b0);
    boot(1'b0, 1'b1, 1'b0);
    // start target inside the vector area must raise the error flag
    boot(1'b1, 1'b0, 1'b1);
    test_done;
  end
endmodule
